// File: shared/cpc_pkg.sv
/*
  Constants for the charge port configuration register bank: offsets,
  reset values, write masks, field positions, state codes and timing.
  Assumes a 40 MHz core clock.
*/
`default_nettype none

package cpc_pkg;

  localparam logic [7:0] GEN_CFG_ADDR = 8'h15;
  localparam logic [7:0] EMU_CFG_ADDR = 8'h16;
  localparam logic [7:0] SW_CFG_ADDR = 8'h17;
  localparam logic [7:0] ATT_CFG_ADDR = 8'h18;
  localparam logic [7:0] HS_CFG_ADDR = 8'h25;

  localparam logic [7:0] GEN_CFG_RST = 8'h01;
  localparam logic [7:0] EMU_CFG_RST = 8'h8C;
  localparam logic [7:0] SW_CFG_RST = 8'h04;
  localparam logic [7:0] ATT_CFG_RST = 8'h46;
  localparam logic [7:0] HS_CFG_RST = 8'h14;

  // Clear bit is a write strobe, never stored
  localparam logic [7:0] GEN_WMASK = 8'hBB;
  localparam logic [7:0] EMU_WMASK = 8'h9F;
  localparam logic [7:0] SW_WMASK = 8'hBF;
  localparam logic [7:0] ATT_WMASK = 8'hFF;
  localparam logic [7:0] HS_WMASK = 8'h1F;

  localparam int GEN_MASK_BIT = 7;
  localparam int GEN_LINK_BIT = 5;
  localparam int GEN_BUS_DISCHARGE_FORCE_BIT = 4;
  localparam int GEN_BEN_BIT = 3;
  localparam int GEN_BCLR_BIT = 2;
  localparam int GEN_ACT_LSB = 0;
  localparam int EMU_BTO_BIT = 7;
  localparam int EMU_TODIS_BIT = 4;
  localparam int EMU_RPT_BIT = 3;
  localparam int EMU_HOLD_BIT = 2;
  localparam int EMU_RLEN_LSB = 0;
  localparam int ATT_DIS_LSB = 2;
  localparam int HS_DCE_BIT = 0;

  typedef enum logic [1:0] {PWR_SLEEP, PWR_DETECT, PWR_ACTIVE, PWR_ERROR} cpc_pwr_t;
  typedef enum logic [1:0] {ACT_REPORT, ACT_DISCONNECT, ACT_SLEEP, ACT_IGNORE} cpc_act_t;

  localparam logic [3:0] PROF_DCP = 4'h0;
  localparam logic [3:0] PROF_LG2 = 4'h2;
  localparam logic [3:0] PROF_CUSTOM = 4'h8;
  localparam logic [3:0] PROF_NONE = 4'h9;
  localparam int NUM_PROFILES = 9;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned PROFILE_TIMEOUT_MS = 1000;
  localparam int unsigned EM_RESET_MS [4] = '{50, 75, 125, 175};
  localparam int unsigned DISCHARGE_MS [4] = '{100, 200, 300, 400};

  // Total emulation reset: selected length plus discharge time
  function automatic int unsigned reset_ms(input logic [1:0] rlen, input logic [1:0] dsel);
    return EM_RESET_MS[rlen] + DISCHARGE_MS[dsel];
  endfunction

  // First enabled profile at or after start, PROF_NONE when none is left
  function automatic logic [3:0] next_profile(input logic [8:0] en, input logic [3:0] start);
    logic [3:0] found;
    found = PROF_NONE;
    for (int i = NUM_PROFILES - 1; i >= 0; i--)
    begin
      if (en[i] && (4'(i) >= start))
        found = 4'(i);
    end
    return found;
  endfunction

endpackage

`default_nettype wire

// File: logic/cpc_sync.sv
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherency between bits.
*/
`timescale 1ns/100ps
`default_nettype none

module cpc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule // cpc_sync

`default_nettype wire

// File: logic/cpc_timer.sv
/*
  Loadable down-counter; pulses done in the same cycle that the count reaches zero.
  Assumes the loader holds load_i for one cycle with a non-zero value.
*/
`timescale 1ns/100ps
`default_nettype none

module cpc_timer #(
  parameter int W = 32
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);

  logic [W-1:0] count_ff;
  logic done_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_ff <= '0;
    else if (load_i)
      count_ff <= value_i;
    else if (count_ff != '0)
      count_ff <= count_ff - W'(1);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      done_ff <= 1'b0;
    else
      done_ff <= !load_i && (count_ff == W'(1));
  end

  assign done_o = done_ff;

endmodule // cpc_timer

`default_nettype wire

// File: logic/cpc_config_regs.sv
/*
  Configuration register bank of the charge port controller with the
  alert, discharge, charge budget and dedicated-charger emulation logic
  that those registers steer.
  Assumes a register port from the management bus engine on core_clk_i,
  status and samples from same-clock logic, and comparator levels from
  the port that arrive unsynchronised.
*/
// Operation
// - Mask bit stops attention pin assertion
// - Link bit lets low-current/thermal drive pin
// - Discharge bit in Active opens switch, discharges
// - Discharge bit holds until software clears
// - Budget disable clears and stops accumulator
// - Budget disable withdraws response, clears flag
// - Clear bit zeroes accumulator and flag
// - Action field: report, disconnect, sleep, ignore
// - Bus time-out disable bit turns time-out off
// - Time-out off: accept whenever current drawn
// - Time-out disable also covers custom profile
// - Time-out on, hold clear: hold profile, judge at expiry
// - Repeat bit restarts cycle after last profile
// - No repeat: hi-Z data, switch closed, custom limit
// - Repeat bit only matters in dedicated mode
// - Hold bit keeps response until removal/heat/restart
// - Held response: short or driven data voltages
// - Hold clear, time-out on: short removed at time-out expiry
// - Reset length 50/75/125/175 ms plus discharge
// - High-speed enable closes switch regardless of hold
// - Configuration kept through Sleep state
// - Power state coded Sleep/Detect/Active/Error
`timescale 1ns/100ps
`default_nettype none

module cpc_config_regs #(
  parameter int unsigned CYC_PER_MS = cpc_pkg::CYC_PER_MS,
  parameter int unsigned PROFILE_TIMEOUT_MS = cpc_pkg::PROFILE_TIMEOUT_MS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire cpc_pkg::cpc_pwr_t power_state_code_i,
  input wire logic dedicated_charger_cycle_i,
  input wire logic [8:0] profile_enable_i,
  input wire logic custom_timeout_en_i,
  input wire logic error_i,
  input wire logic low_current_flag_i,
  input wire logic thermal_regulation_flag_i,
  input wire logic [15:0] current_sample_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] budget_threshold_i,
  input wire logic charge_current_threshold_i,
  input wire logic removal_i,
  input wire logic over_temp_i,
  output logic alert_o,
  output logic alert_oe_o,
  output logic bus_timeout_en_o,
  output logic port_switch_close_o,
  output logic bus_discharge_o,
  output logic sleep_request_o,
  output logic [15:0] accumulated_charge_o,
  output logic budget_exceeded_flag_o,
  output logic data_plus_out_oe_o,
  output logic data_minus_out_oe_o,
  output logic data_line_short_o,
  output logic [3:0] active_profile_o,
  output logic custom_limit_sel_o,
  output logic hs_switch_close_o
);
  import cpc_pkg::*;

  typedef enum logic [2:0] {EM_IDLE, EM_RESET, EM_APPLY, EM_CHARGE, EM_HOLD, EM_DONE}
    cpc_em_state_t;

  logic [7:0] gen_cfg_ff;
  logic [7:0] emu_cfg_ff;
  logic [7:0] sw_cfg_ff;
  logic [7:0] att_cfg_ff;
  logic [7:0] hs_cfg_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [15:0] acc_ff;
  logic [16:0] acc_sum;
  logic flag_ff;
  logic alert_oe_ff;
  logic bus_to_en_ff;
  logic switch_ff;
  logic discharge_ff;
  logic sleep_ff;
  logic dp_oe_ff;
  logic dm_oe_ff;
  logic short_ff;
  logic [3:0] prof_out_ff;
  logic custom_lim_ff;
  logic hs_ff;
  cpc_em_state_t state_ff;
  cpc_em_state_t nxt_state;
  logic [3:0] prof_ff;
  logic [3:0] nxt_prof;
  logic drawn_ff;
  logic tmr_load;
  logic [31:0] tmr_val;
  logic tmr_done;
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic ibus_s;
  logic removal_s;
  logic otemp_s;
  logic active;
  logic clr_pulse;
  logic budget_en;
  cpc_act_t action;
  logic disconnect;
  logic to_off;
  logic hold_en;
  logic short_prof;
  logic [3:0] first_prof;
  logic [3:0] follow_prof;
  logic [31:0] reset_cyc;
  logic [31:0] profile_cyc;

  assign active = (power_state_code_i == PWR_ACTIVE);
  assign budget_en = gen_cfg_ff[GEN_BEN_BIT];
  assign action = cpc_act_t'(gen_cfg_ff[GEN_ACT_LSB +: 2]);
  assign hold_en = emu_cfg_ff[EMU_HOLD_BIT];
  assign clr_pulse = reg_wr_i && (reg_addr_i == GEN_CFG_ADDR) && reg_wdata_i[GEN_BCLR_BIT];
  assign short_prof = (prof_ff == PROF_DCP) || (prof_ff == PROF_LG2);
  assign first_prof = next_profile(profile_enable_i, 4'h0);
  assign follow_prof = next_profile(profile_enable_i, prof_ff + 4'h1);
  assign reset_cyc = reset_ms(emu_cfg_ff[EMU_RLEN_LSB +: 2],
                              att_cfg_ff[ATT_DIS_LSB +: 2]) * CYC_PER_MS;
  assign profile_cyc = PROFILE_TIMEOUT_MS * CYC_PER_MS;
  // Custom profile's own enable loses to the global disable
  assign to_off = emu_cfg_ff[EMU_TODIS_BIT] ||
                  ((prof_ff == PROF_CUSTOM) && !custom_timeout_en_i);

  assign sync_in = {charge_current_threshold_i, removal_i, over_temp_i};
  assign ibus_s = sync_out[2];
  assign removal_s = sync_out[1];
  assign otemp_s = sync_out[0];

  cpc_sync #(
    .W(3)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(sync_in),
    .sync_o(sync_out)
  );

  cpc_timer #(
    .W(32)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );

  // Only the async reset and register writes touch these, so power state changes keep them
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gen_cfg_ff <= GEN_CFG_RST;
      emu_cfg_ff <= EMU_CFG_RST;
      sw_cfg_ff <= SW_CFG_RST;
      att_cfg_ff <= ATT_CFG_RST;
      hs_cfg_ff <= HS_CFG_RST;
    end
    else if (reg_wr_i)
    begin
      // Discharge bit changes only through this write path
      if (reg_addr_i == GEN_CFG_ADDR)
        gen_cfg_ff <= reg_wdata_i & GEN_WMASK;
      if (reg_addr_i == EMU_CFG_ADDR)
        emu_cfg_ff <= reg_wdata_i & EMU_WMASK;
      if (reg_addr_i == SW_CFG_ADDR)
        sw_cfg_ff <= reg_wdata_i & SW_WMASK;
      if (reg_addr_i == ATT_CFG_ADDR)
        att_cfg_ff <= reg_wdata_i & ATT_WMASK;
      if (reg_addr_i == HS_CFG_ADDR)
        hs_cfg_ff <= reg_wdata_i & HS_WMASK;
    end
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (reg_addr_i)
      GEN_CFG_ADDR: nxt_rdata = gen_cfg_ff;
      EMU_CFG_ADDR: nxt_rdata = emu_cfg_ff;
      SW_CFG_ADDR: nxt_rdata = sw_cfg_ff;
      ATT_CFG_ADDR: nxt_rdata = att_cfg_ff;
      HS_CFG_ADDR: nxt_rdata = hs_cfg_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  // Saturates rather than wraps so a long session never looks fresh
  assign acc_sum = {1'b0, acc_ff} + {1'b0, current_sample_i};

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_ff <= 16'h0000;
    else if (!budget_en || clr_pulse)
      acc_ff <= 16'h0000;
    else if (sample_valid_i)
      acc_ff <= acc_sum[16] ? 16'hFFFF : acc_sum[15:0];
  end

  // Clear wins over a threshold hit in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_ff <= 1'b0;
    else if (!budget_en || clr_pulse || (action == ACT_IGNORE))
      flag_ff <= 1'b0;
    else if (acc_ff >= budget_threshold_i)
      flag_ff <= 1'b1;
  end

  assign disconnect = flag_ff && ((action == ACT_DISCONNECT) || (action == ACT_SLEEP));

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alert_oe_ff <= 1'b0;
    else
      alert_oe_ff <= !gen_cfg_ff[GEN_MASK_BIT] &&
                     (error_i || flag_ff ||
                      (gen_cfg_ff[GEN_LINK_BIT] &&
                       (low_current_flag_i || thermal_regulation_flag_i)));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_to_en_ff <= 1'b0;
    else
      bus_to_en_ff <= !emu_cfg_ff[EMU_BTO_BIT];
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_prof = prof_ff;
    tmr_load = 1'b0;
    tmr_val = reset_cyc;
    if (!active || !dedicated_charger_cycle_i)
      nxt_state = EM_IDLE;
    else
    begin
      unique case (state_ff)
        EM_IDLE:
        begin
          nxt_state = EM_RESET;
          tmr_load = 1'b1;
        end
        EM_RESET:
        begin
          if (tmr_done && (first_prof == PROF_NONE))
            nxt_state = EM_DONE;
          else if (tmr_done)
          begin
            nxt_state = EM_APPLY;
            nxt_prof = first_prof;
            tmr_load = 1'b1;
            tmr_val = profile_cyc;
          end
        end
        EM_APPLY:
        begin
          if (removal_s)
          begin
            nxt_state = EM_RESET;
            tmr_load = 1'b1;
          end
          else if (ibus_s && (hold_en || to_off))
            nxt_state = hold_en ? EM_HOLD : EM_CHARGE;
          else if (tmr_done && !to_off)
          begin
            if (drawn_ff || ibus_s)
              nxt_state = EM_CHARGE;
            else if (follow_prof != PROF_NONE)
            begin
              nxt_prof = follow_prof;
              tmr_load = 1'b1;
              tmr_val = profile_cyc;
            end
            else if (emu_cfg_ff[EMU_RPT_BIT])
            begin
              nxt_state = EM_RESET;
              tmr_load = 1'b1;
            end
            else
              nxt_state = EM_DONE;
          end
        end
        EM_CHARGE, EM_HOLD, EM_DONE:
        begin
          if (removal_s)
          begin
            nxt_state = EM_RESET;
            tmr_load = 1'b1;
          end
          else if ((state_ff == EM_HOLD) && otemp_s)
            nxt_state = EM_CHARGE;
        end
        default: nxt_state = EM_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= EM_IDLE;
      prof_ff <= PROF_NONE;
    end
    else
    begin
      state_ff <= nxt_state;
      prof_ff <= nxt_prof;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      drawn_ff <= 1'b0;
    else if (tmr_load || (state_ff != EM_APPLY))
      drawn_ff <= 1'b0;
    else if (ibus_s)
      drawn_ff <= 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      switch_ff <= 1'b0;
      discharge_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end
    else
    begin
      switch_ff <= active && !gen_cfg_ff[GEN_BUS_DISCHARGE_FORCE_BIT] && !disconnect &&
                   (state_ff != EM_RESET);
      discharge_ff <= active && (gen_cfg_ff[GEN_BUS_DISCHARGE_FORCE_BIT] || (state_ff == EM_RESET));
      sleep_ff <= flag_ff && (action == ACT_SLEEP);
    end
  end

  // Data lines float in DONE and CHARGE; held response only in HOLD
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dp_oe_ff <= 1'b0;
      dm_oe_ff <= 1'b0;
      short_ff <= 1'b0;
      prof_out_ff <= PROF_NONE;
      custom_lim_ff <= 1'b0;
    end
    else
    begin
      dp_oe_ff <= ((state_ff == EM_APPLY) || (state_ff == EM_HOLD)) && !short_prof;
      dm_oe_ff <= ((state_ff == EM_APPLY) || (state_ff == EM_HOLD)) && !short_prof;
      short_ff <= ((state_ff == EM_APPLY) || (state_ff == EM_HOLD)) && short_prof;
      prof_out_ff <= prof_ff;
      custom_lim_ff <= (state_ff == EM_DONE);
    end
  end

  // Closing while a short is held blocks traffic; software clears hold first
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hs_ff <= 1'b0;
    else
      hs_ff <= active && hs_cfg_ff[HS_DCE_BIT] &&
               ((state_ff == EM_CHARGE) || (state_ff == EM_HOLD));
  end

  assign reg_rdata_o = rdata_ff;
  assign alert_o = 1'b0;
  assign alert_oe_o = alert_oe_ff;
  assign bus_timeout_en_o = bus_to_en_ff;
  assign port_switch_close_o = switch_ff;
  assign bus_discharge_o = discharge_ff;
  assign sleep_request_o = sleep_ff;
  assign accumulated_charge_o = acc_ff;
  assign budget_exceeded_flag_o = flag_ff;
  assign data_plus_out_oe_o = dp_oe_ff;
  assign data_minus_out_oe_o = dm_oe_ff;
  assign data_line_short_o = short_ff;
  assign active_profile_o = prof_out_ff;
  assign custom_limit_sel_o = custom_lim_ff;
  assign hs_switch_close_o = hs_ff;

  a_mask_alert: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    gen_cfg_ff[GEN_MASK_BIT] |=> !alert_oe_o)
    else $error("alert asserted while masked");

  a_link_alert: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !gen_cfg_ff[GEN_MASK_BIT] && gen_cfg_ff[GEN_LINK_BIT] && low_current_flag_i |=> alert_oe_o)
    else $error("linked indicator did not raise alert");

  a_discharge_open: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    active && gen_cfg_ff[GEN_BUS_DISCHARGE_FORCE_BIT] |=> !port_switch_close_o && bus_discharge_o)
    else $error("discharge did not open switch");

  a_bus_discharge_force_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    gen_cfg_ff[GEN_BUS_DISCHARGE_FORCE_BIT] && !(reg_wr_i && reg_addr_i == GEN_CFG_ADDR)
      |=> gen_cfg_ff[GEN_BUS_DISCHARGE_FORCE_BIT])
    else $error("discharge bit cleared itself");

  a_budget_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !budget_en |=> accumulated_charge_o == 16'h0000 && !budget_exceeded_flag_o)
    else $error("budget disable did not clear");

  a_budget_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clr_pulse |=> accumulated_charge_o == 16'h0000 && !budget_exceeded_flag_o)
    else $error("budget clear ignored");

  a_ignore_action: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    action == ACT_IGNORE |=> !budget_exceeded_flag_o ##1 !sleep_request_o)
    else $error("ignore action still flagged");

  a_bus_timeout: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    emu_cfg_ff[EMU_BTO_BIT] ##1 emu_cfg_ff[EMU_BTO_BIT] |-> !bus_timeout_en_o)
    else $error("bus time-out not disabled");

  a_done_float: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_ff == EM_DONE && active && !disconnect && !gen_cfg_ff[GEN_BUS_DISCHARGE_FORCE_BIT]
      |=> port_switch_close_o && !data_line_short_o && !data_plus_out_oe_o && custom_limit_sel_o)
    else $error("finished cycle output wrong");

  a_hs_close: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    active && hs_cfg_ff[HS_DCE_BIT] && state_ff == EM_HOLD |=> hs_switch_close_o)
    else $error("high-speed switch not closed");

  a_reg_unimpl: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    reg_addr_i == EMU_CFG_ADDR |=> reg_rdata_o[6:5] == 2'b00)
    else $error("unimplemented bits read nonzero");

endmodule // cpc_config_regs

`default_nettype wire

// File: bench/cpc_port_dev.sv
/*
  Attached portable device: starts drawing charging current once a
  charger response has stood for delay_i cycles, keeps drawing until
  the bench unplugs it. Assumes the bench gates it with draw_en_i.
*/
`timescale 1ns/100ps
`default_nettype none

module cpc_port_dev (
  input wire logic core_clk_i,
  input wire logic draw_en_i,
  input wire logic [7:0] delay_i,
  input wire logic resp_i,
  output logic draw_o
);
  logic [7:0] cnt_ff = 8'h00;
  logic draw_ff = 1'b0;

  // Saturating count, so a long response never wraps into a false start
  always_ff @(posedge core_clk_i)
  begin
    cnt_ff <= resp_i ? cnt_ff + 8'(cnt_ff != 8'hFF) : 8'h00;
    draw_ff <= draw_en_i && (draw_ff || (resp_i && cnt_ff >= delay_i));
  end

  assign draw_o = draw_ff;
endmodule // cpc_port_dev

`default_nettype wire

// File: bench/tb_cpc_config_regs.sv
/*
  Bench for the charge port configuration bank.
  Assumes cpc_pkg is compiled first; times shortened to 4 cycles/ms.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end

module tb_cpc_config_regs;
  import cpc_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, ded = 0, smp_v = 0, err = 0, lowc = 0, therm = 0, otemp = 0;
  logic draw = 0, unplug = 0, cur, alert, aoe, bto, psw, dsc, slp, flag, dp, dm, sh, cl, hs;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [15:0] smp = 16'h0004, thr = 16'h000A, acc;
  logic [8:0] pen = 9'h001;
  logic [3:0] prof;
  cpc_pwr_t pst = PWR_DETECT;
  int num_errors = 0, cmp_count = 0;

  cpc_config_regs #(.CYC_PER_MS(4), .PROFILE_TIMEOUT_MS(4)) cpc_config_regs_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wd), .reg_rdata_o(rdata), .power_state_code_i(pst),
    .dedicated_charger_cycle_i(ded), .profile_enable_i(pen), .custom_timeout_en_i(1'b0),
    .error_i(err), .low_current_flag_i(lowc), .thermal_regulation_flag_i(therm),
    .current_sample_i(smp), .sample_valid_i(smp_v), .budget_threshold_i(thr),
    .charge_current_threshold_i(cur), .removal_i(unplug), .over_temp_i(otemp),
    .alert_o(alert), .alert_oe_o(aoe), .bus_timeout_en_o(bto), .port_switch_close_o(psw),
    .bus_discharge_o(dsc), .sleep_request_o(slp), .accumulated_charge_o(acc),
    .budget_exceeded_flag_o(flag), .data_plus_out_oe_o(dp), .data_minus_out_oe_o(dm),
    .data_line_short_o(sh), .active_profile_o(prof), .custom_limit_sel_o(cl),
    .hs_switch_close_o(hs));

  cpc_port_dev cpc_port_dev_inst (.core_clk_i(clk), .draw_en_i(draw), .delay_i(8'h03),
    .resp_i(sh | dp), .draw_o(cur));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    `CHK(n, e, rdata)
  endtask

  // Bounded wait for a profile to be applied; the index alone lingers after a cycle
  task automatic wait_prof(input logic [3:0] e, input int lim);
    for (int i = 0; i < lim && !(prof === e && (sh | dp) === 1'b1); i++)
      @(negedge clk);
    `CHK("profile", e, prof)
    `CHK("response on", 1'b1, sh | dp)
    if (prof !== e || (sh | dp) !== 1'b1)
      report_and_stop();
  endtask

  task automatic t_regs;
    logic [7:0] ad [5] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h25};
    logic [7:0] rv [5] = '{8'h01, 8'h8C, 8'h04, 8'h46, 8'h14};
    logic [7:0] mk [5] = '{GEN_WMASK, EMU_WMASK, SW_WMASK, ATT_WMASK, HS_WMASK};
    for (int i = 0; i < 5; i++)
    begin
      rd_chk(ad[i], rv[i], "reset value");
      wr_reg(ad[i], 8'hFF);
      rd_chk(ad[i], mk[i], "masked bits");
      wr_reg(ad[i], rv[i]);
    end
    rd_chk(8'h20, 8'h00, "unmapped");
    `CHK("bus timeout off", 1'b0, bto)
    wr_reg(EMU_CFG_ADDR, 8'h0C);
    wt(1);
    `CHK("bus timeout on", 1'b1, bto)
    pst = PWR_SLEEP;
    rd_chk(EMU_CFG_ADDR, 8'h0C, "kept in sleep");
    pst = PWR_DETECT;
    $display("t_regs done");
  endtask

  task automatic t_alert;
    err = 1;
    wt(3);
    `CHK("alert on error", 1'b1, aoe)
    `CHK("alert level", 1'b0, alert)
    wr_reg(GEN_CFG_ADDR, 8'h81);
    wt(2);
    `CHK("alert masked", 1'b0, aoe)
    err = 0;
    lowc = 1;
    wr_reg(GEN_CFG_ADDR, 8'h01);
    wt(2);
    `CHK("alert unlinked", 1'b0, aoe)
    wr_reg(GEN_CFG_ADDR, 8'h21);
    wt(2);
    `CHK("alert linked", 1'b1, aoe)
    lowc = 0;
    therm = 1;
    wt(2);
    `CHK("thermal linked", 1'b1, aoe)
    therm = 0;
    wr_reg(GEN_CFG_ADDR, 8'h01);
    $display("t_alert done");
  endtask

  task automatic t_dsc;
    wr_reg(GEN_CFG_ADDR, 8'h11);
    wt(2);
    `CHK("no discharge in detect", 1'b0, dsc)
    pst = PWR_ACTIVE;
    wt(30);
    `CHK("switch open", 1'b0, psw)
    `CHK("discharge held", 1'b1, dsc)
    rd_chk(GEN_CFG_ADDR, 8'h11, "discharge bit kept");
    wr_reg(GEN_CFG_ADDR, 8'h01);
    wt(2);
    `CHK("discharge off", 1'b0, dsc)
    `CHK("switch closed", 1'b1, psw)
    pst = PWR_DETECT;
    $display("t_dsc done");
  endtask

  task automatic pulses;
    repeat (3)
    begin
      @(negedge clk);
      smp_v = 1;
      @(negedge clk);
      smp_v = 0;
    end
    wt(3);
  endtask

  task automatic t_budget;
    for (int a = 0; a < 4; a++)
    begin
      wr_reg(GEN_CFG_ADDR, 8'h0C | 8'(a));
      rd_chk(GEN_CFG_ADDR, 8'h08 | 8'(a), "clear not stored");
      `CHK("acc cleared", 16'h0000, acc)
      `CHK("flag cleared", 1'b0, flag)
      pulses();
      `CHK("acc sum", 16'h000C, acc)
      `CHK("flag", 1'(a != 3), flag)
      `CHK("sleep request", 1'(a == 2), slp)
    end
    wr_reg(GEN_CFG_ADDR, 8'h0D);
    pulses();
    `CHK("flag set", 1'b1, flag)
    wr_reg(GEN_CFG_ADDR, 8'h01);
    pulses();
    `CHK("acc off", 16'h0000, acc)
    `CHK("flag withdrawn", 1'b0, flag)
    $display("t_budget done");
  endtask

  // Emulation reset 175 ms plus 200 ms discharge, then DCP, then done
  task automatic t_emu_done;
    wr_reg(EMU_CFG_ADDR, 8'h03);
    pst = PWR_ACTIVE;
    ded = 1;
    wt(1480);
    `CHK("still in reset", 4'h9, prof)
    `CHK("discharging", 1'b1, dsc)
    wait_prof(PROF_DCP, 60);
    `CHK("dcp short", 1'b1, sh)
    wt(40);
    `CHK("done short off", 1'b0, sh)
    `CHK("done hi z", 2'b00, {dp, dm})
    `CHK("done switch", 1'b1, psw)
    `CHK("done limit", 1'b1, cl)
    ded = 0;
    $display("t_emu_done done");
  endtask

  // Nothing drawn with repeat on: back through emulation reset, not done
  task automatic t_emu_rpt;
    wr_reg(EMU_CFG_ADDR, 8'h08);
    ded = 1;
    wait_prof(PROF_DCP, 1100);
    wt(20);
    `CHK("repeat resets", 1'b1, dsc)
    `CHK("repeat short off", 1'b0, sh)
    `CHK("repeat not done", 1'b0, cl)
    ded = 0;
    $display("t_emu_rpt done");
  endtask

  task automatic t_emu_hold;
    wr_reg(EMU_CFG_ADDR, 8'h04);
    wr_reg(HS_CFG_ADDR, 8'h15);
    draw = 1;
    ded = 1;
    wait_prof(PROF_DCP, 1100);
    wt(60);
    `CHK("held short", 1'b1, sh)
    `CHK("hs closed", 1'b1, hs)
    unplug = 1;
    draw = 0;
    wt(8);
    `CHK("released on removal", 1'b0, sh)
    unplug = 0;
    draw = 1;
    wait_prof(PROF_DCP, 1100);
    wt(20);
    otemp = 1;
    wt(6);
    `CHK("heat ends hold", 1'b0, sh)
    otemp = 0;
    draw = 0;
    ded = 0;
    $display("t_emu_hold done");
  endtask

  task automatic t_emu_noto;
    wr_reg(EMU_CFG_ADDR, 8'h10);
    ded = 1;
    wait_prof(PROF_DCP, 1100);
    wt(200);
    `CHK("no time-out exit", PROF_DCP, prof)
    `CHK("short kept", 1'b1, sh)
    draw = 1;
    wt(12);
    `CHK("accepted late", 1'b0, sh)
    `CHK("hs after accept", 1'b1, hs)
    draw = 0;
    ded = 0;
    wr_reg(EMU_CFG_ADDR, 8'h0C);
    $display("t_emu_noto done");
  endtask

  initial
  begin
    wt(12);
    rst_n = 1;
    t_regs();
    t_alert();
    t_dsc();
    t_budget();
    t_emu_done();
    t_emu_rpt();
    t_emu_hold();
    t_emu_noto();
    report_and_stop();
  end
endmodule // tb_cpc_config_regs

`default_nettype wire
